/* File: bt_pkg.sv */
// constants and carrier types for the baseband modem core
package bt_pkg;
	localparam int unsigned CLK_MHZ       = 200;
	localparam int unsigned SYM_KHZ       = 1000;
	localparam int unsigned SYM_CYC       = CLK_MHZ * 1000 / SYM_KHZ;
	localparam int unsigned HALF_SLOT_NS  = 312500;
	localparam int unsigned HALF_SLOT_CYC = HALF_SLOT_NS * CLK_MHZ / 1000;
	localparam logic [7:0]  HEC_POLY      = 8'hA7;
	localparam logic [15:0] CRC_POLY      = 16'h1021;
	localparam logic [4:0]  HAM_POLY      = 5'h15;
	localparam logic [33:0] SYNC_POLY     = 34'h260534236;
	localparam logic [29:0] SYNC_PN       = 30'h3F2A33DD;
	localparam logic [5:0]  BARKER_0      = 6'h13;
	localparam logic [5:0]  BARKER_1      = 6'h2C;
	localparam logic [3:0]  PRE_0         = 4'h5;
	localparam logic [3:0]  PRE_1         = 4'hA;
	localparam logic [6:0]  HOP_CHANS     = 7'h4F;
	localparam int unsigned AC_MISS_MAX   = 7;
	localparam logic [15:0] CIPH_POLY     = 16'hB400;
	typedef enum logic [1:0] {RATE_BASIC, RATE_DQPSK, RATE_8DPSK} rate_t;
	typedef enum logic [2:0] {F_AC, F_HDR, F_GUARD, F_SYNC, F_PAY, F_TRL} field_t;
	typedef struct packed {
		rate_t       rate;
		logic [1:0]  hop_mode;
		logic [23:0] lap;
		logic [7:0]  uap;
		logic [7:0]  prescale;
		logic        enc_en;
		logic [15:0] key;
	} cfg_t;
	typedef struct packed {
		logic       valid;
		field_t     field;
		logic [2:0] bits;
	} sym_t;
	typedef struct packed {
		logic       valid;
		logic [2:0] step;
		logic [2:0] phase;
		logic       fsk;
	} mod_t;
endpackage : bt_pkg

/* File: bt_baseband_modem_core.sv */
// baseband modem core: timebase, task timers, mapper, coders, checks, cipher
`timescale 1ns/1ps
`default_nettype none
module bt_baseband_modem_core
	import bt_pkg::*;
#(
	parameter int unsigned HALF_CYC = HALF_SLOT_CYC
)(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire cfg_t        cfg,
	input  wire logic        tmr_wr,
	input  wire logic [1:0]  tmr_sel,
	input  wire logic [27:0] tmr_at,
	input  wire sym_t        sym_in,
	input  wire logic        pkt_start,
	input  wire logic        bs_valid,
	input  wire logic        bs_bit,
	input  wire logic        bs_hdr,
	input  wire logic        hdr_end,
	input  wire logic [7:0]  hdr_rx_hec,
	input  wire logic        pay_end,
	input  wire logic [15:0] pay_rx_crc,
	input  wire logic [9:0]  ham_data,
	input  wire logic [14:0] ham_rx,
	input  wire logic        rx_valid,
	input  wire logic        rx_bit,
	output logic [27:0]      nclk_q,
	output logic [15:0]      phase_q,
	output logic             tick_q,
	output logic             sym_en_q,
	output logic [2:0]       task_q,
	output logic [6:0]       hop_q,
	output mod_t             mod_q,
	output logic             order_err_q,
	output logic [71:0]      ac_q,
	output logic             ac_hit_q,
	output logic [2:0]       rep_q,
	output logic [14:0]      ham_code_q,
	output logic [9:0]       ham_dec_q,
	output logic [7:0]       hec_q,
	output logic             hec_bad_q,
	output logic [15:0]      crc_q,
	output logic             crc_bad_q,
	output logic             ct_bit_q
);
	function automatic logic [2:0] step_of(rate_t r, logic [2:0] b);
		logic [2:0] s;
		s = 3'h0;
		if (r == RATE_DQPSK)
			case (b[1:0])
				2'h0: s = 3'h1;
				2'h1: s = 3'h3;
				2'h3: s = 3'h5;
				default: s = 3'h7;
			endcase
		else
			case (b)
				3'h0: s = 3'h0;
				3'h1: s = 3'h1;
				3'h3: s = 3'h2;
				3'h2: s = 3'h3;
				3'h6: s = 3'h4;
				3'h7: s = 3'h5;
				3'h5: s = 3'h6;
				default: s = 3'h7;
			endcase
		return s;
	endfunction : step_of

	function automatic logic [4:0] ham_syn(logic [14:0] w);
		logic [4:0] r;
		r = 5'h0;
		for (int i = 14; i >= 0; i--)
			r = {r[3:0], 1'b0} ^ ((r[4] ^ w[i]) ? HAM_POLY : 5'h0);
		return r;
	endfunction : ham_syn

	function automatic logic [71:0] ac_of(logic [23:0] lap);
		logic [29:0] inf;
		logic [33:0] par;
		logic [63:0] sw;
		inf = {(lap[23] ? BARKER_1 : BARKER_0), lap} ^ SYNC_PN;
		par = 34'h0;
		for (int i = 29; i >= 0; i--)
			par = {par[32:0], 1'b0} ^ ((par[33] ^ inf[i]) ? SYNC_POLY : 34'h0);
		sw = {inf, par};
		return {(sw[63] ? PRE_1 : PRE_0), sw, (sw[0] ? PRE_0 : PRE_1)};
	endfunction : ac_of

	// timebase
	logic [7:0]  sdiv_q, sdiv_d, pre_q, pre_d;
	logic [15:0] phase_d;
	logic [27:0] nclk_d;
	logic        tick_d, sym_en_d;
	always_comb
	begin
		sdiv_d   = (sdiv_q == 8'(SYM_CYC - 1)) ? 8'h0 : sdiv_q + 8'h1;
		sym_en_d = (sdiv_q == 8'(SYM_CYC - 1));
		pre_d    = pre_q;
		phase_d  = phase_q;
		nclk_d   = nclk_q;
		tick_d   = 1'b0;
		if (pre_q >= cfg.prescale)
		begin
			pre_d = 8'h0;
			if (phase_q == 16'(HALF_CYC - 1))
			begin
				phase_d = 16'h0;
				nclk_d  = nclk_q + 28'h1;
				tick_d  = 1'b1;
			end
			else
				phase_d = phase_q + 16'h1;
		end
		else
			pre_d = pre_q + 8'h1;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sdiv_q   <= 8'h0;
			sym_en_q <= 1'b0;
			pre_q    <= 8'h0;
			phase_q  <= 16'h0;
			nclk_q   <= 28'h0;
			tick_q   <= 1'b0;
		end
		else
		begin
			sdiv_q   <= sdiv_d;
			sym_en_q <= sym_en_d;
			pre_q    <= pre_d;
			phase_q  <= phase_d;
			nclk_q   <= nclk_d;
			tick_q   <= tick_d;
		end
	end

	// timers: 0 transmit, 1 receive, 2 general
	logic [27:0] at_q [3];
	logic [27:0] at_d [3];
	logic [2:0]  arm_q, arm_d, task_d;
	logic [6:0]  hop_d;
	always_comb
	begin
		at_d   = at_q;
		arm_d  = arm_q;
		task_d = 3'h0;
		for (int i = 0; i < 3; i++)
		begin
			if (tick_d && arm_q[i] && nclk_d == at_q[i])
			begin
				task_d[i] = 1'b1;
				arm_d[i]  = 1'b0;
			end
		end
		// firmware programs a timer
		if (tmr_wr && tmr_sel != 2'h3)
		begin
			at_d[tmr_sel]  = tmr_at;
			arm_d[tmr_sel] = 1'b1;
		end
		hop_d = 7'(({4'h0, nclk_q[27:1]} ^ {5'h0, cfg.lap, cfg.hop_mode}) % 31'(HOP_CHANS));
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			at_q   <= '{default: 28'h0};
			arm_q  <= 3'h0;
			task_q <= 3'h0;
			hop_q  <= 7'h0;
		end
		else
		begin
			at_q   <= at_d;
			arm_q  <= arm_d;
			task_q <= task_d;
			hop_q  <= hop_d;
		end
	end

	// symbol mapper and field order tracker
	field_t fld_q, fld_d;
	mod_t   mod_d;
	logic   oerr_d;
	always_comb
	begin
		fld_d        = fld_q;
		mod_d        = mod_q;
		mod_d.valid  = 1'b0;
		oerr_d       = 1'b0;
		if (pkt_start)
			fld_d = F_AC;
		else if (sym_en_q && sym_in.valid)
		begin
			case (fld_q)
				F_AC, F_HDR, F_GUARD, F_SYNC, F_PAY, F_TRL: oerr_d = sym_in.field < fld_q;
				default: oerr_d = 1'b1;
			endcase
			fld_d       = oerr_d ? fld_q : sym_in.field;
			mod_d.valid = 1'b1;
			// multi-bit phase only in payload
			if (cfg.rate != RATE_BASIC && sym_in.field == F_PAY)
			begin
				mod_d.step  = step_of(cfg.rate, sym_in.bits);
				mod_d.phase = mod_q.phase + mod_d.step;
				mod_d.fsk   = 1'b0;
			end
			else
			begin
				mod_d.step = 3'h0;
				mod_d.fsk  = sym_in.bits[0];
			end
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			fld_q       <= F_AC;
			mod_q       <= '0;
			order_err_q <= 1'b0;
		end
		else
		begin
			fld_q       <= fld_d;
			mod_q       <= mod_d;
			order_err_q <= oerr_d;
		end
	end

	// access code, correlator, coders
	logic [63:0] rx_sh_q, rx_sh_d;
	logic        hit_d;
	logic [4:0]  syn;
	logic [14:0] fix;
	logic [6:0]  miss;
	always_comb
	begin
		rx_sh_d = rx_valid ? {rx_sh_q[62:0], rx_bit} : rx_sh_q;
		miss    = 7'h0;
		for (int i = 0; i < 64; i++)
			miss = miss + 7'(rx_sh_d[i] ^ ac_q[4 + i]);
		hit_d = rx_valid && miss <= 7'(AC_MISS_MAX);
		syn   = ham_syn(ham_rx);
		fix   = ham_rx;
		for (int i = 0; i < 15; i++)
			if (syn != 5'h0 && ham_syn(15'h1 << i) == syn)
				fix[i] = ~ham_rx[i];
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_sh_q    <= 64'h0;
			ac_q       <= 72'h0;
			ac_hit_q   <= 1'b0;
			rep_q      <= 3'h0;
			ham_code_q <= 15'h0;
			ham_dec_q  <= 10'h0;
		end
		else
		begin
			rx_sh_q    <= rx_sh_d;
			ac_q       <= ac_of(cfg.lap);
			ac_hit_q   <= hit_d;
			rep_q      <= (bs_valid && !bs_hdr) ? 3'h0 : {3{bs_bit}};
			// parity is data times x^5 reduced, so the codeword divides evenly
			ham_code_q <= {ham_data, ham_syn({5'h0, ham_data})};
			ham_dec_q  <= fix[14:5];
		end
	end

	// header check, payload crc, cipher stream
	logic [7:0]  hec_d;
	logic [15:0] crc_d, ks_q, ks_d;
	logic        hbad_d, cbad_d, ct_d;
	always_comb
	begin
		hec_d  = hec_q;
		crc_d  = crc_q;
		ks_d   = ks_q;
		ct_d   = ct_bit_q;
		hbad_d = hec_bad_q;
		cbad_d = crc_bad_q;
		if (pkt_start)
		begin
			hec_d  = cfg.uap;
			crc_d  = {cfg.uap, 8'h00};
			ks_d   = cfg.key ^ nclk_q[15:0] | 16'h1;
			hbad_d = 1'b0;
			cbad_d = 1'b0;
		end
		else if (bs_valid && bs_hdr)
			hec_d = {hec_q[6:0], 1'b0} ^ ((hec_q[7] ^ bs_bit) ? HEC_POLY : 8'h0);
		else if (bs_valid)
		begin
			crc_d = {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ bs_bit) ? CRC_POLY : 16'h0);
			ks_d  = {ks_q[14:0], ^(ks_q & CIPH_POLY)};
			ct_d  = bs_bit ^ (cfg.enc_en & ks_q[15]);
		end
		// compare against received check fields
		if (hdr_end)
			hbad_d = hec_q != hdr_rx_hec;
		if (pay_end)
			cbad_d = crc_q != pay_rx_crc;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hec_q     <= 8'h0;
			crc_q     <= 16'h0;
			ks_q      <= 16'h1;
			ct_bit_q  <= 1'b0;
			hec_bad_q <= 1'b0;
			crc_bad_q <= 1'b0;
		end
		else
		begin
			hec_q     <= hec_d;
			crc_q     <= crc_d;
			ks_q      <= ks_d;
			ct_bit_q  <= ct_d;
			hec_bad_q <= hbad_d;
			crc_bad_q <= cbad_d;
		end
	end

	sequence s_wrap;
		tick_q ##1 !tick_q;
	endsequence
	property p_tick;
		@(posedge clk) disable iff (rst) tick_q |-> phase_q == 16'h0 && nclk_q == $past(nclk_q) + 28'h1;
	endproperty
	a_tick: assert property (p_tick) else $error("native clock tick wrong");
	property p_phase;
		@(posedge clk) disable iff (rst) phase_q < 16'(HALF_CYC);
	endproperty
	a_phase: assert property (p_phase) else $error("phase out of range");
	property p_sym;
		@(posedge clk) disable iff (rst) sym_en_q |=> !sym_en_q [*8];
	endproperty
	a_sym: assert property (p_sym) else $error("symbol enable too fast");
	property p_task;
		@(posedge clk) disable iff (rst) task_q != 3'h0 |-> tick_q;
	endproperty
	a_task: assert property (p_task) else $error("task launched off tick");
	property p_qpsk;
		@(posedge clk) disable iff (rst)
			mod_q.valid && $past(cfg.rate) == RATE_DQPSK && $past(sym_in.field) == F_PAY |-> mod_q.step[0];
	endproperty
	a_qpsk: assert property (p_qpsk) else $error("even step in two-bit mode");
	property p_mphase;
		@(posedge clk) disable iff (rst) mod_q.valid |-> mod_q.phase == $past(mod_q.phase) + mod_q.step;
	endproperty
	a_mphase: assert property (p_mphase) else $error("phase not accumulated");
	property p_ham;
		@(posedge clk) disable iff (rst) ##1 ham_syn(ham_code_q) == 5'h0;
	endproperty
	a_ham: assert property (p_ham) else $error("codeword has syndrome");
	property p_slot;
		@(posedge clk) disable iff (rst) s_wrap |-> nclk_q == $past(nclk_q);
	endproperty
	a_slot: assert property (p_slot) else $error("clock moved without tick");
endmodule : bt_baseband_modem_core
`default_nettype wire

/* File: radio_partner.sv */
// radio front end stand-in that plays received bits into the correlator
`timescale 1ns/1ps
`default_nettype none
module radio_partner (
	input  wire logic clk,
	output logic      rx_valid,
	output logic      rx_bit
);
	initial
	begin
		rx_valid = 1'b0;
		rx_bit   = 1'b0;
	end
	// idle line toggles every idle cycle, starting from the inverse of the last bit, so a stale level never matches
	task automatic send(input logic [63:0] w, input int gap);
		for (int i = 63; i >= 0; i--)
		begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_bit   = w[i];
			repeat (gap)
			begin
				@(negedge clk);
				rx_valid = 1'b0;
				rx_bit   = ~rx_bit;
			end
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_bit   = ~rx_bit;
	endtask : send
endmodule : radio_partner
`default_nettype wire

/* File: test_bt_baseband_modem_core.sv */
// self-checking bench for the baseband modem core
`timescale 1ns/1ps
`default_nettype none
module test_bt_baseband_modem_core
	import bt_pkg::*;
;
	localparam int HALF = 20;
	logic clk, rst, tmr_wr, pkt_start, bs_valid, bs_bit, bs_hdr, hdr_end, pay_end;
	logic tick_q, sym_en_q, order_err_q, ac_hit_q, hec_bad_q, crc_bad_q, ct_bit_q;
	cfg_t cfg;
	sym_t sym_in;
	mod_t mod_q;
	logic [1:0] tmr_sel;
	logic [27:0] tmr_at, nclk_q;
	logic [7:0] hdr_rx_hec, hec_q;
	logic [15:0] pay_rx_crc, phase_q, crc_q;
	logic [9:0] ham_data, ham_dec_q;
	logic [14:0] ham_rx, ham_code_q;
	logic [2:0] task_q, rep_q;
	logic [6:0] hop_q;
	logic [71:0] ac_q;
	wire rx_valid, rx_bit;
	int bad_count, checks, hits;
	logic [2:0] dq [4] = '{3'h1, 3'h3, 3'h7, 3'h5};
	logic [2:0] d8 [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h7, 3'h6, 3'h4, 3'h5};

	bt_baseband_modem_core #(.HALF_CYC(HALF)) DUT (.clk, .rst, .cfg, .tmr_wr, .tmr_sel, .tmr_at, .sym_in,
		.pkt_start, .bs_valid, .bs_bit, .bs_hdr, .hdr_end, .hdr_rx_hec, .pay_end, .pay_rx_crc, .ham_data,
		.ham_rx, .rx_valid, .rx_bit, .nclk_q, .phase_q, .tick_q, .sym_en_q, .task_q, .hop_q, .mod_q,
		.order_err_q, .ac_q, .ac_hit_q, .rep_q, .ham_code_q, .ham_dec_q, .hec_q, .hec_bad_q, .crc_q,
		.crc_bad_q, .ct_bit_q);
	radio_partner radio (.clk, .rx_valid, .rx_bit);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(negedge clk)
		if (ac_hit_q === 1'b1)
			hits++;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic complete_run();
		if (bad_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	// counts negedges until the flag shows, giving up after lim
	task automatic wait_flag(input string nm, ref logic f, input int lim, output int n);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (f !== 1'b1 && n < lim);
		if (f !== 1'b1)
		begin
			chk(nm, 0, 1);
			complete_run();
		end
	endtask : wait_flag

	task automatic t_time(input int ps);
		logic [27:0] n0;
		int n;
		@(negedge clk);
		cfg.prescale = ps[7:0];
		wait_flag("tick_q", tick_q, 400, n);
		n0 = nclk_q;
		wait_flag("tick_q", tick_q, 400, n);
		chk("half_cycles", n, HALF * (ps + 1));
		chk("nclk_q", nclk_q, n0 + 28'h1);
		chk("phase_q", phase_q, 0);
		chk("hop_q_range", hop_q < HOP_CHANS, 1);
		wait_flag("sym_en_q", sym_en_q, 300, n);
		wait_flag("sym_en_q", sym_en_q, 300, n);
		chk("sym_cycles", n, SYM_CYC);
	endtask : t_time

	task automatic t_timer();
		logic [27:0] at;
		int n;
		for (int s = 0; s < 4; s++)
		begin
			@(negedge clk);
			at = nclk_q + 28'h2;
			tmr_wr = 1'b1;
			tmr_sel = s[1:0];
			tmr_at = at;
			@(negedge clk);
			tmr_wr = 1'b0;
			n = 0;
			while (task_q === 3'h0 && n < 4 * HALF)
			begin
				@(negedge clk);
				n++;
			end
			chk("task_q", task_q, (s < 3) ? (3'h1 << s) : 3'h0);
			if (s < 3)
			begin
				chk("task_nclk", nclk_q, at);
				chk("task_tick", tick_q, 1);
			end
		end
	endtask : t_timer

	task automatic map_one(input field_t f, input logic [2:0] b, input logic [2:0] st, input logic oe);
		logic [2:0] ph;
		int n;
		ph = mod_q.phase;
		wait_flag("sym_en_q", sym_en_q, 300, n);
		sym_in = '{valid: 1'b1, field: f, bits: b};
		@(negedge clk);
		sym_in.valid = 1'b0;
		n = 0;
		while (mod_q.valid !== 1'b1 && n < 3)
		begin
			@(negedge clk);
			n++;
		end
		chk("mod_valid", mod_q.valid, 1);
		chk("mod_step", mod_q.step, st);
		chk("mod_phase", mod_q.phase, 3'(ph + st));
		if (cfg.rate == RATE_BASIC || f != F_PAY)
			chk("mod_fsk", mod_q.fsk, b[0]);
		chk("order_err_q", order_err_q, oe);
	endtask : map_one

	task automatic t_map();
		@(negedge clk);
		pkt_start = 1'b1;
		@(negedge clk);
		pkt_start = 1'b0;
		cfg.rate = RATE_BASIC;
		map_one(F_AC, 3'h1, 3'h0, 1'b0);
		map_one(F_HDR, 3'h0, 3'h0, 1'b0);
		cfg.rate = RATE_DQPSK;
		map_one(F_GUARD, 3'h1, 3'h0, 1'b0);
		map_one(F_SYNC, 3'h0, 3'h0, 1'b0);
		for (int b = 0; b < 4; b++)
			map_one(F_PAY, b[2:0], dq[b], 1'b0);
		cfg.rate = RATE_8DPSK;
		for (int b = 0; b < 8; b++)
			map_one(F_PAY, b[2:0], d8[b], 1'b0);
		map_one(F_TRL, 3'h0, 3'h0, 1'b0);
		map_one(F_HDR, 3'h1, 3'h0, 1'b1);
		cfg.rate = RATE_BASIC;
	endtask : t_map

	task automatic t_checks(input logic bad);
		logic [7:0] h;
		logic [15:0] c, ks;
		logic [25:0] bits;
		h = cfg.uap;
		c = {cfg.uap, 8'h00};
		bits = {16'hC3A9, 10'h2B5};
		cfg.enc_en = bad;
		@(negedge clk);
		pkt_start = 1'b1;
		// keystream seed uses the clock value that the start edge samples
		ks = (cfg.key ^ nclk_q[15:0]) | 16'h0001;
		@(negedge clk);
		pkt_start = 1'b0;
		for (int i = 0; i < 26; i++)
		begin
			@(negedge clk);
			bs_valid = 1'b1;
			bs_bit = bits[i];
			bs_hdr = (i < 10);
			if (i < 10)
				h = {h[6:0], 1'b0} ^ ((h[7] ^ bits[i]) ? HEC_POLY : 8'h00);
			else
				c = {c[14:0], 1'b0} ^ ((c[15] ^ bits[i]) ? CRC_POLY : 16'h0000);
			@(negedge clk);
			bs_valid = 1'b0;
			chk("rep_q", rep_q, (i < 10) ? {3{bits[i]}} : 3'h0);
			if (i >= 10)
			begin
				chk("ct_bit_q", ct_bit_q, bits[i] ^ (cfg.enc_en & ks[15]));
				ks = {ks[14:0], ^(ks & CIPH_POLY)};
			end
			if (i == 9)
			begin
				hdr_end = 1'b1;
				hdr_rx_hec = h ^ {7'h00, bad};
				@(negedge clk);
				hdr_end = 1'b0;
				@(negedge clk);
				chk("hec_q", hec_q, h);
				chk("hec_bad_q", hec_bad_q, bad);
			end
		end
		pay_end = 1'b1;
		pay_rx_crc = c ^ {15'h0000, bad};
		@(negedge clk);
		pay_end = 1'b0;
		@(negedge clk);
		chk("crc_q", crc_q, c);
		chk("crc_bad_q", crc_bad_q, bad);
	endtask : t_checks

	task automatic t_ham();
		for (int p = 0; p < 15; p++)
		begin
			@(negedge clk);
			ham_data = 10'h2A5 ^ p[9:0];
			@(negedge clk);
			chk("ham_code_q", ham_code_q[14:5], ham_data);
			ham_rx = ham_code_q ^ (15'h0001 << p);
			@(negedge clk);
			chk("ham_dec_q", ham_dec_q, ham_data);
		end
	endtask : t_ham

	task automatic t_corr();
		logic [63:0] w;
		w = ac_q[67:4];
		chk("preamble", ac_q[71:68], ac_q[67] ? PRE_1 : PRE_0);
		chk("trailer", ac_q[3:0], ac_q[4] ? PRE_0 : PRE_1);
		chk("sync_lap", ac_q[67:38] ^ SYNC_PN, {cfg.lap[23] ? BARKER_1 : BARKER_0, cfg.lap});
		hits = 0;
		radio.send(w ^ 64'h0101_0101_0101_0100, 0);
		repeat (3) @(negedge clk);
		chk("ac_hit_q", hits > 0, 1);
		hits = 0;
		radio.send(~w, 1);
		repeat (3) @(negedge clk);
		chk("ac_hit_count", hits, 0);
	endtask : t_corr

	initial
	begin
		{rst, tmr_wr, tmr_sel, tmr_at, pkt_start, bs_valid, bs_bit, bs_hdr} = {1'b1, 35'h0};
		{hdr_end, pay_end, hdr_rx_hec, pay_rx_crc, ham_data, ham_rx} = '0;
		sym_in = '0;
		cfg = '{rate: RATE_BASIC, hop_mode: 2'h1, lap: 24'h5A3C96, uap: 8'h47, prescale: 8'h00,
			enc_en: 1'b0, key: 16'h1234};
		repeat (5) @(negedge clk);
		chk("nclk_q_reset", nclk_q, 0);
		rst = 1'b0;
		t_time(1);
		t_time(0);
		t_timer();
		t_map();
		t_checks(1'b0);
		t_checks(1'b1);
		t_ham();
		t_corr();
		complete_run();
	end
endmodule : test_bt_baseband_modem_core
`default_nettype wire
